// ### mac_rst_loop_ctrl.sv
// Overview of operation
// - Soft reset request self-clears when sequence ends
// - Soft reset stops paths, flushes, clears counters
// - Soft reset keeps configuration registers unchanged
// - Enables cleared; paths stop after current frame
// - Hardware reset clears all logic
// - Loopback feeds transmit output into receive
// - ECC detects double, corrects single errors
// - ECC covers FIFOs, retransmit, counters, hash
// - One two-bit ECC status output, ORed over all channels
// - Counters not cleared without line clocks
//
// Top of the MAC reset, loopback and ECC control, Wishbone classic slave.
// Assumes a single 10 MHz clock; PHY receive pins and line status are
// asynchronous and synchronised here; MAC side signals share the clock.
//
// Design decisions made here: the address map and register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none
module mac_rst_loop_ctrl (
   input  wire logic                                    clk_i,
   input  wire logic                                    rst_i,
   input  wire logic                                    wb_cyc_i,
   input  wire logic                                    wb_stb_i,
   input  wire logic                                    wb_we_i,
   input  wire logic [7:0]                              wb_adr_i,
   input  wire logic [3:0]                              wb_sel_i,
   input  wire logic [31:0]                             wb_dat_i,
   output logic      [31:0]                             wb_dat_o,
   output logic                                         wb_ack_o,
   input  wire logic [7:0]                              mac_txd_i,
   input  wire logic                                    mac_tx_en_i,
   input  wire logic                                    mac_tx_er_i,
   output logic      [7:0]                              phy_txd_o,
   output logic                                         phy_tx_en_o,
   output logic                                         phy_tx_er_o,
   input  wire logic [7:0]                              phy_rxd_i,
   input  wire logic                                    phy_rx_dv_i,
   input  wire logic                                    phy_rx_er_i,
   output logic      [7:0]                              mac_rxd_o,
   output logic                                         mac_rx_dv_o,
   output logic                                         mac_rx_er_o,
   input  wire logic                                    line_clk_ok_i,
   output logic                                         fifo_flush_o,
   output logic                                         stats_clear_o,
   output logic      [47:0]                             station_addr_o,
   output logic      [15:0]                             fifo_thresh_o,
   input  wire logic [mac_ctrl_pkg::ECC_MEM_COUNT-1:0]
                     [mac_ctrl_pkg::ECC_CW_W-1:0]        ecc_cw_i,
   output logic      [mac_ctrl_pkg::ECC_MEM_COUNT-1:0]
                     [mac_ctrl_pkg::ECC_DATA_W-1:0]      ecc_data_o,
   output logic      [1:0]                              ecc_status_o
);

   typedef struct packed {
      logic        transmit_path_enable;
      logic        receive_path_enable;
      logic        loop;
      logic        sw_req;
      logic [47:0] mac_addr;
      logic [15:0] thresh;
      logic [31:0] tx_cnt;
      logic [31:0] rx_cnt;
      logic        tx_run;
      logic        rx_run;
      logic [9:0]  rx_s1;
      logic [9:0]  rx_s2;
      logic        lok_s1;
      logic        lok_s2;
      logic [9:0]  phy_tx;
      logic [9:0]  mac_rx;
      logic        ack;
      logic [31:0] dat;
      logic        flush;
      logic        sclr;
   } ctrl_reg_type;

   ctrl_reg_type q;
   ctrl_reg_type d;
   soft_reset_if rc ();

   logic        req;
   logic        wr;
   logic [7:0]  adr_w;
   logic        tx_go;
   logic        rx_go;
   logic [9:0]  rx_src;
   logic [31:0] cmd_w;
   logic [31:0] wv;
   logic [1:0]  ecc_st;

   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  sel);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) r[8*b +: 8] = new_v[8*b +: 8];
      end
      return r;
   endfunction : merge

   soft_reset_seq u_seq (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .ctl   (rc.seq)
   );

   ecc_monitor u_ecc (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .cw_i     (ecc_cw_i),
      .data_o   (ecc_data_o),
      .status_o (ecc_st)
   );

   assign rc.start   = q.sw_req;
   assign rc.tx_busy = q.tx_run;
   assign rc.rx_busy = q.rx_run;
   assign rc.line_ok = q.lok_s2;

   always_comb begin
      d      = q;
      req    = wb_cyc_i & wb_stb_i;
      adr_w  = {wb_adr_i[7:2], 2'b00};
      // Writes commit on the edge that the master samples ack
      wr     = req & wb_we_i & q.ack;
      d.ack  = req & ~q.ack;
      cmd_w  = cmd_word(q);
      wv     = 32'h0000_0000;
      d.dat  = 32'h0000_0000;

      if (req & ~q.ack & ~wb_we_i) begin
         case (adr_w)
            mac_ctrl_pkg::ADR_CMD:    d.dat = cmd_w;
            mac_ctrl_pkg::ADR_STATUS: begin
               d.dat[mac_ctrl_pkg::ST_BUSY]    = rc.busy;
               d.dat[mac_ctrl_pkg::ST_TX_RUN]  = q.tx_run;
               d.dat[mac_ctrl_pkg::ST_RX_RUN]  = q.rx_run;
               d.dat[mac_ctrl_pkg::ST_LINE_OK] = q.lok_s2;
               d.dat[mac_ctrl_pkg::ST_ECC_LSB +: 2] = ecc_st;
            end
            mac_ctrl_pkg::ADR_ADDRLO: d.dat = q.mac_addr[31:0];
            mac_ctrl_pkg::ADR_ADDRHI: d.dat = {16'h0000, q.mac_addr[47:32]};
            mac_ctrl_pkg::ADR_THRESH: d.dat = {16'h0000, q.thresh};
            mac_ctrl_pkg::ADR_TXCNT:  d.dat = q.tx_cnt;
            mac_ctrl_pkg::ADR_RXCNT:  d.dat = q.rx_cnt;
            default:                  d.dat = 32'h0000_0000;
         endcase
      end

      // Request drops only when the sequence ends; a new set wins
      if (rc.done) d.sw_req = 1'b0;
      if (wr) begin
         case (adr_w)
            mac_ctrl_pkg::ADR_CMD: begin
               wv       = merge(cmd_w, wb_dat_i, wb_sel_i);
               d.transmit_path_enable = wv[mac_ctrl_pkg::CMD_TRANSMIT_PATH_ENABLE];
               d.receive_path_enable = wv[mac_ctrl_pkg::CMD_RECEIVE_PATH_ENABLE];
               d.loop   = wv[mac_ctrl_pkg::CMD_LOOP];
               // Only a written one arms; a masked lane must not re-arm at done
               d.sw_req = d.sw_req | (wb_sel_i[0] & wb_dat_i[mac_ctrl_pkg::CMD_SWRST]);
            end
            mac_ctrl_pkg::ADR_ADDRLO: begin
               d.mac_addr[31:0] = merge(q.mac_addr[31:0], wb_dat_i, wb_sel_i);
            end
            mac_ctrl_pkg::ADR_ADDRHI: begin
               wv = merge({16'h0000, q.mac_addr[47:32]}, wb_dat_i, wb_sel_i);
               d.mac_addr[47:32] = wv[15:0];
            end
            mac_ctrl_pkg::ADR_THRESH: begin
               wv       = merge({16'h0000, q.thresh}, wb_dat_i, wb_sel_i);
               d.thresh = wv[15:0];
            end
            default: begin
               wv = 32'h0000_0000;
            end
         endcase
      end
      // Enables held low for the whole sequence, re-armed only by software
      if (d.sw_req | rc.busy) begin
         d.transmit_path_enable = 1'b0;
         d.receive_path_enable = 1'b0;
      end

      // A frame already started runs to its end
      tx_go    = mac_tx_en_i & (q.tx_run | q.transmit_path_enable);
      d.tx_run = tx_go;
      d.phy_tx = tx_go ? {1'b1, mac_tx_er_i, mac_txd_i} : 10'h000;

      d.rx_s1  = {phy_rx_dv_i, phy_rx_er_i, phy_rxd_i};
      d.rx_s2  = q.rx_s1;
      d.lok_s1 = line_clk_ok_i;
      d.lok_s2 = q.lok_s1;
      // Loopback takes the registered transmit pins and skips the two receive synchroniser stages
      rx_src   = q.loop ? q.phy_tx : q.rx_s2;
      rx_go    = rx_src[9] & (q.rx_run | q.receive_path_enable);
      d.rx_run = rx_go;
      d.mac_rx = rx_go ? rx_src : 10'h000;

      if (q.tx_run & ~tx_go) d.tx_cnt = q.tx_cnt + 32'h0000_0001;
      if (q.rx_run & ~rx_go) d.rx_cnt = q.rx_cnt + 32'h0000_0001;
      // Station address and threshold are not touched here
      if (rc.stats_clear) begin
         d.tx_cnt = 32'h0000_0000;
         d.rx_cnt = 32'h0000_0000;
      end
      d.flush = rc.flush;
      d.sclr  = rc.stats_clear;
   end

   function automatic logic [31:0] cmd_word(input ctrl_reg_type s);
      logic [31:0] r;
      r = mac_ctrl_pkg::REG_RESET;
      r[mac_ctrl_pkg::CMD_TRANSMIT_PATH_ENABLE] = s.transmit_path_enable;
      r[mac_ctrl_pkg::CMD_RECEIVE_PATH_ENABLE] = s.receive_path_enable;
      r[mac_ctrl_pkg::CMD_LOOP]   = s.loop;
      r[mac_ctrl_pkg::CMD_SWRST]  = s.sw_req;
      return r;
   endfunction : cmd_word

   always_ff @(posedge clk_i) begin
      if (rst_i) q <= '0;
      else       q <= d;
   end

   assign wb_dat_o       = q.dat;
   assign wb_ack_o       = q.ack;
   assign phy_txd_o      = q.phy_tx[7:0];
   assign phy_tx_er_o    = q.phy_tx[8];
   assign phy_tx_en_o    = q.phy_tx[9];
   assign mac_rxd_o      = q.mac_rx[7:0];
   assign mac_rx_er_o    = q.mac_rx[8];
   assign mac_rx_dv_o    = q.mac_rx[9];
   assign fifo_flush_o   = q.flush;
   assign stats_clear_o  = q.sclr;
   assign station_addr_o = q.mac_addr;
   assign fifo_thresh_o  = q.thresh;
   assign ecc_status_o   = ecc_st;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_self_clear;
      $fell(q.sw_req) |-> $past(rc.done);
   endproperty
   a_self_clear: assert property (p_self_clear) else $error("request cleared early");

   property p_cnt_clear;
      rc.stats_clear |=> q.tx_cnt == 32'h0000_0000 && q.rx_cnt == 32'h0000_0000;
   endproperty
   a_cnt_clear: assert property (p_cnt_clear) else $error("counters not cleared");

   property p_cfg_keep;
      rc.busy && !wr |=> $stable(q.mac_addr) && $stable(q.thresh);
   endproperty
   a_cfg_keep: assert property (p_cfg_keep) else $error("config changed by reset");

   property p_frame_runs;
      q.tx_run && mac_tx_en_i |=> q.tx_run;
   endproperty
   a_frame_runs: assert property (p_frame_runs) else $error("frame cut short");

   property p_ena_off;
      q.sw_req |-> !q.transmit_path_enable && !q.receive_path_enable;
   endproperty
   a_ena_off: assert property (p_ena_off) else $error("enable set during reset");

   property p_loop_path;
      $past(q.loop) && q.mac_rx[9] |-> q.mac_rx == $past(q.phy_tx);
   endproperty
   a_loop_path: assert property (p_loop_path) else $error("loopback data wrong");

   property p_line_gate;
      rc.stats_clear |-> $past(q.lok_s2);
   endproperty
   a_line_gate: assert property (p_line_gate) else $error("clear without line clock");

   property p_stay_off;
      $fell(rc.busy) |-> !q.transmit_path_enable && !q.receive_path_enable;
   endproperty
   a_stay_off: assert property (p_stay_off) else $error("path enabled after reset");

   property p_tx_idle_off;
      !q.tx_run && !q.transmit_path_enable |=> !q.tx_run;
   endproperty
   a_tx_idle_off: assert property (p_tx_idle_off) else $error("tx started while off");

   property p_rx_idle_off;
      !q.rx_run && !q.receive_path_enable |=> !q.rx_run;
   endproperty
   a_rx_idle_off: assert property (p_rx_idle_off) else $error("rx started while off");

   property p_flush_out;
      rc.flush |=> fifo_flush_o;
   endproperty
   a_flush_out: assert property (p_flush_out) else $error("flush not driven");

   property p_line_path;
      !$past(q.loop) && q.mac_rx[9] |-> q.mac_rx == $past(q.rx_s2);
   endproperty
   a_line_path: assert property (p_line_path) else $error("line receive data wrong");

   c_reset_done: cover property (rc.done);
   c_loop_frame: cover property (q.loop && q.mac_rx[9]);
   c_clear_skip: cover property (rc.flush && !q.lok_s2);

endmodule : mac_rst_loop_ctrl
`default_nettype wire

// ### mac_ctrl_pkg.sv
// Constants, register map and types for the MAC reset, loopback and ECC control.
// Assumes a 10 MHz system clock and a Wishbone slave with 32-bit data.
package mac_ctrl_pkg;

   localparam int CLK_PERIOD_NS = 100;
   localparam int CLEAR_TIME_NS = 400;
   localparam int CLEAR_CYCLES  = (CLEAR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [2:0] CLEAR_CNT_INIT = 3'(CLEAR_CYCLES - 1);

   localparam logic [7:0] ADR_CMD    = 8'h00;
   localparam logic [7:0] ADR_STATUS = 8'h04;
   localparam logic [7:0] ADR_ADDRLO = 8'h08;
   localparam logic [7:0] ADR_ADDRHI = 8'h0C;
   localparam logic [7:0] ADR_THRESH = 8'h10;
   localparam logic [7:0] ADR_TXCNT  = 8'h14;
   localparam logic [7:0] ADR_RXCNT  = 8'h18;

   localparam int CMD_TRANSMIT_PATH_ENABLE = 0;
   localparam int CMD_RECEIVE_PATH_ENABLE = 1;
   localparam int CMD_LOOP   = 2;
   localparam int CMD_SWRST  = 3;

   localparam int ST_BUSY    = 0;
   localparam int ST_TX_RUN  = 1;
   localparam int ST_RX_RUN  = 2;
   localparam int ST_LINE_OK = 3;
   localparam int ST_ECC_LSB = 4;

   localparam logic [31:0] REG_RESET = 32'h0000_0000;

   // Tx FIFO, rx FIFO, retransmit buffer, statistics, multicast hash
   localparam int ECC_MEM_COUNT = 5;
   localparam int ECC_DATA_W    = 8;
   localparam int ECC_CW_W      = 13;
   localparam logic [1:0] ECC_OK    = 2'h0;
   localparam logic [1:0] ECC_FIXED = 2'h1;
   localparam logic [1:0] ECC_FATAL = 2'h2;

   typedef enum logic [1:0] {
      SEQ_IDLE  = 2'h0,
      SEQ_DRAIN = 2'h1,
      SEQ_CLEAR = 2'h2,
      SEQ_DONE  = 2'h3
   } seq_state_type;

endpackage : mac_ctrl_pkg

// ### soft_reset_if.sv
// Handshake between the register block and the soft reset sequencer.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface soft_reset_if;
   logic start;
   logic tx_busy;
   logic rx_busy;
   logic line_ok;
   logic busy;
   logic done;
   logic flush;
   logic stats_clear;
   modport seq  (input start, tx_busy, rx_busy, line_ok,
                 output busy, done, flush, stats_clear);
   modport ctrl (output start, tx_busy, rx_busy, line_ok,
                 input busy, done, flush, stats_clear);
endinterface : soft_reset_if
`default_nettype wire

// ### soft_reset_seq.sv
// Soft reset sequencer: drain frames, flush buffers, clear counters, finish.
// Assumes start stays high until done has been seen.
`timescale 1ns/100ps
`default_nettype none
module soft_reset_seq (
   input  wire logic   clk_i,
   input  wire logic   rst_i,
   soft_reset_if.seq   ctl
);

   typedef struct packed {
      mac_ctrl_pkg::seq_state_type st;
      logic [2:0]                  cnt;
      logic                        flush;
      logic                        clr;
      logic                        done;
   } seq_reg_type;

   seq_reg_type q;
   seq_reg_type d;

   always_comb begin
      d      = q;
      d.done = 1'b0;
      case (q.st)
         mac_ctrl_pkg::SEQ_IDLE: begin
            if (ctl.start) d.st = mac_ctrl_pkg::SEQ_DRAIN;
         end
         mac_ctrl_pkg::SEQ_DRAIN: begin
            // Current frames finish before anything is flushed
            if (!ctl.tx_busy && !ctl.rx_busy) begin
               d.st  = mac_ctrl_pkg::SEQ_CLEAR;
               d.cnt = mac_ctrl_pkg::CLEAR_CNT_INIT;
            end
         end
         mac_ctrl_pkg::SEQ_CLEAR: begin
            if (q.cnt == 3'h0) begin
               d.st   = mac_ctrl_pkg::SEQ_DONE;
               d.done = 1'b1;
            end else begin
               d.cnt = q.cnt - 3'h1;
            end
         end
         mac_ctrl_pkg::SEQ_DONE: begin
            d.st = mac_ctrl_pkg::SEQ_IDLE;
         end
         default: begin
            d.st = mac_ctrl_pkg::SEQ_IDLE;
         end
      endcase
      d.flush = (d.st == mac_ctrl_pkg::SEQ_CLEAR);
      // Counters live on line clocks; without them the clear is skipped
      d.clr   = d.flush & ctl.line_ok;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) q <= '0;
      else       q <= d;
   end

   assign ctl.busy        = (q.st != mac_ctrl_pkg::SEQ_IDLE);
   assign ctl.done        = q.done;
   assign ctl.flush       = q.flush;
   assign ctl.stats_clear = q.clr;

   property p_flush_len;
      @(posedge clk_i) disable iff (rst_i)
      $rose(q.flush) |-> q.flush [*4] ##1 q.done;
   endproperty
   a_flush_len: assert property (p_flush_len) else $error("flush length wrong");

   c_drain_wait: cover property (@(posedge clk_i) disable iff (rst_i)
      q.st == mac_ctrl_pkg::SEQ_DRAIN && ctl.tx_busy);

endmodule : soft_reset_seq
`default_nettype wire

// ### ecc_monitor.sv
// SECDED checker for the protected memories: corrects single, flags double errors.
// Assumes codewords arrive with overall parity in bit 0, Hamming bits 1..12.
`timescale 1ns/100ps
`default_nettype none
module ecc_monitor (
   input  wire logic                                    clk_i,
   input  wire logic                                    rst_i,
   input  wire logic [mac_ctrl_pkg::ECC_MEM_COUNT-1:0]
                     [mac_ctrl_pkg::ECC_CW_W-1:0]        cw_i,
   output logic      [mac_ctrl_pkg::ECC_MEM_COUNT-1:0]
                     [mac_ctrl_pkg::ECC_DATA_W-1:0]      data_o,
   output logic      [1:0]                              status_o
);

   typedef struct packed {
      logic [mac_ctrl_pkg::ECC_MEM_COUNT-1:0][mac_ctrl_pkg::ECC_DATA_W-1:0] data;
      logic [1:0]                                                            st;
   } ecc_reg_type;

   ecc_reg_type q;
   ecc_reg_type d;
   logic [mac_ctrl_pkg::ECC_MEM_COUNT-1:0] par;

   function automatic logic [9:0] secded_fix(input logic [12:0] cw);
      logic [3:0]  s;
      logic [12:0] c;
      logic [1:0]  st;
      s  = 4'h0;
      c  = cw;
      st = mac_ctrl_pkg::ECC_OK;
      for (int i = 1; i < 13; i++) begin
         if (cw[i]) s = s ^ 4'(i);
      end
      if (^cw) begin
         if (s < 4'hD) begin
            st   = mac_ctrl_pkg::ECC_FIXED;
            c[s] = ~c[s];
         end else begin
            st = mac_ctrl_pkg::ECC_FATAL;
         end
      end else if (s != 4'h0) begin
         st = mac_ctrl_pkg::ECC_FATAL;
      end
      return {st, c[12], c[11], c[10], c[9], c[7], c[6], c[5], c[3]};
   endfunction : secded_fix

   always_comb begin
      logic [9:0] r;
      r    = 10'h000;
      d    = q;
      d.st = mac_ctrl_pkg::ECC_OK;
      for (int m = 0; m < mac_ctrl_pkg::ECC_MEM_COUNT; m++) begin
         r         = secded_fix(cw_i[m]);
         d.data[m] = r[7:0];
         d.st      = d.st | r[9:8];
      end
   end

   always_comb begin
      for (int m = 0; m < mac_ctrl_pkg::ECC_MEM_COUNT; m++) par[m] = ^cw_i[m];
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) q <= '0;
      else       q <= d;
   end

   assign data_o   = q.data;
   assign status_o = q.st;

   property p_single_flag;
      @(posedge clk_i) disable iff (rst_i)
      (|par) |=> status_o != mac_ctrl_pkg::ECC_OK;
   endproperty
   a_single_flag: assert property (p_single_flag) else $error("odd parity not flagged");

   property p_ok_clean;
      @(posedge clk_i) disable iff (rst_i)
      status_o[0] |-> $past(|par);
   endproperty
   a_ok_clean: assert property (p_ok_clean) else $error("fix flagged without error");

   c_fix: cover property (@(posedge clk_i) disable iff (rst_i)
      status_o == mac_ctrl_pkg::ECC_FIXED);

endmodule : ecc_monitor
`default_nettype wire

// ### mac_rst_loop_ctrl_tb.sv
// Self-checking bench for the MAC reset, loopback and ECC control block.
// Assumes the design files are compiled first; one 10 MHz clock, no partner.
`timescale 1ns/100ps
`default_nettype none
module mac_rst_loop_ctrl_tb;
   localparam logic [7:0] CMD = mac_ctrl_pkg::ADR_CMD;
   logic        clk_i   = 1'b0;
   logic        rst_i   = 1'b1;
   logic        cyc     = 1'b0;
   logic        stb     = 1'b0;
   logic        we      = 1'b0;
   logic [7:0]  adr     = 8'h00;
   logic [31:0] wdat    = 32'h0;
   logic [31:0] rdat;
   logic [31:0] rnd     = 32'h4F58E532;
   logic [31:0] a;
   logic [7:0]  txd     = 8'h00;
   logic [7:0]  rxd     = 8'h00;
   logic        tx_en   = 1'b0;
   logic        rx_dv   = 1'b0;
   logic        line_ok = 1'b1;
   logic [mac_ctrl_pkg::ECC_MEM_COUNT-1:0][mac_ctrl_pkg::ECC_CW_W-1:0]   cw = '0;
   logic [mac_ctrl_pkg::ECC_MEM_COUNT-1:0][mac_ctrl_pkg::ECC_CW_W-1:0]   c;
   logic [mac_ctrl_pkg::ECC_MEM_COUNT-1:0][mac_ctrl_pkg::ECC_DATA_W-1:0] edat;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic [7:0]  phy_txd_o;
   logic        phy_tx_en_o;
   logic        phy_tx_er_o;
   logic        mac_rx_er_o;
   logic [7:0]  mac_rxd_o;
   logic        mac_rx_dv_o;
   logic        fifo_flush_o;
   logic        stats_clear_o;
   logic [47:0] sta;
   logic [15:0] thr;
   logic [1:0]  est;
   logic        flush_seen;
   logic        sclr_seen;
   logic [7:0]  b[9];
   logic [7:0]  dd[5];
   int          mismatches = 0;
   int          checks     = 0;
   int          p;

   mac_rst_loop_ctrl u_mac_rst_loop_ctrl (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .mac_txd_i(txd), .mac_tx_en_i(tx_en), .mac_tx_er_i(txd[0]),
      .phy_txd_o(phy_txd_o), .phy_tx_en_o(phy_tx_en_o), .phy_tx_er_o(phy_tx_er_o),
      .phy_rxd_i(rxd), .phy_rx_dv_i(rx_dv), .phy_rx_er_i(1'b0), .mac_rxd_o(mac_rxd_o),
      .mac_rx_dv_o(mac_rx_dv_o), .mac_rx_er_o(mac_rx_er_o), .line_clk_ok_i(line_ok),
      .fifo_flush_o(fifo_flush_o), .stats_clear_o(stats_clear_o),
      .station_addr_o(sta), .fifo_thresh_o(thr), .ecc_cw_i(cw),
      .ecc_data_o(edat), .ecc_status_o(est));

   always #50 clk_i = ~clk_i;

   always @(posedge clk_i) begin
      if (fifo_flush_o === 1'b1) flush_seen = 1'b1;
      if (stats_clear_o === 1'b1) sclr_seen = 1'b1;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
   endfunction : lfsr

   // Expected codeword: even overall parity in bit 0, Hamming parity at 1,2,4,8
   function automatic logic [12:0] enc(input logic [7:0] d);
      logic [12:0] e;
      e = '0;
      {e[12:9], e[7:5], e[3]} = d;
      for (int k = 0; k < 4; k++)
         for (int j = 1; j < 13; j++)
            if (j[k]) e[1 << k] ^= e[j];
      e[0] = ^e[12:1];
      return e;
   endfunction : enc

   task automatic test_done;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : test_done

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Holds the request until ack is seen; slave latency is not assumed
   task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] dt);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= ad;
      wdat <= dt;
      // Ack and read data taken at the rising edge; only the watchdog ends a hang
      do begin
         @(posedge clk_i);
      end while (wb_ack_o !== 1'b1);
      rdat = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask : wb

   task automatic wait_rst;
      int n;
      n = 0;
      do begin
         wb(1'b0, CMD, 32'h0);
         n++;
      end while (rdat[3] !== 1'b0 && n < 40);
      chk(rdat & 32'hB, 32'h0);
   endtask : wait_rst

   task automatic swrst(input logic [31:0] keep);
      wb(1'b1, CMD, keep | 32'h8);
      wait_rst();
   endtask : swrst

   // Sends n bytes; ok says the path is enabled, lp that loopback is on
   task automatic frame(input int n, input logic ok, input logic lp);
      for (int i = 0; i < n + 2; i++) begin
         @(posedge clk_i);
         rnd = lfsr(rnd);
         b[i] = rnd[7:0];
         txd <= rnd[7:0];
         tx_en <= (i < n);
         rxd <= rnd[15:8];
         rx_dv <= lp && (i < n);
         @(negedge clk_i);
         if (i >= 1) chk(phy_tx_en_o, ok && i <= n);
         if (i >= 1 && i <= n && ok) chk({phy_tx_er_o, phy_txd_o}, {b[i-1][0], b[i-1]});
         if (i >= 2) chk(mac_rx_dv_o, ok && lp);
         if (i >= 2 && ok && lp) chk({mac_rx_er_o, mac_rxd_o}, {b[i-2][0], b[i-2]});
      end
   endtask : frame

   initial begin
      repeat (20000) @(posedge clk_i);
      mismatches++;
      test_done();
   end

   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      wb(1'b1, 8'h1C, rnd);
      foreach (b[i]) b[i] = 8'h00;
      for (int i = 0; i < 8; i++) begin
         wb(1'b0, 8'(i * 4), 32'h0);
         if (i != 1) chk(rdat, 32'h0);
      end
      $display("done: reset values");
      rnd = lfsr(rnd);
      a = rnd;
      wb(1'b1, mac_ctrl_pkg::ADR_ADDRLO, a);
      wb(1'b1, mac_ctrl_pkg::ADR_ADDRHI, {16'h0, a[15:0]});
      wb(1'b1, mac_ctrl_pkg::ADR_THRESH, {16'h0, ~a[15:0]});
      chk(sta, {a[15:0], a});
      swrst(32'h0);
      wb(1'b1, CMD, 32'h4);
      wb(1'b1, CMD, 32'h7);
      frame(4, 1'b1, 1'b1);
      frame(3, 1'b1, 1'b1);
      wb(1'b0, mac_ctrl_pkg::ADR_TXCNT, 32'h0);
      chk(rdat, 32'h2);
      wb(1'b0, mac_ctrl_pkg::ADR_RXCNT, 32'h0);
      chk(rdat, 32'h2);
      $display("done: loopback");
      flush_seen = 1'b0;
      sclr_seen = 1'b0;
      swrst(32'h4);
      chk({flush_seen, sclr_seen}, 32'h3);
      wb(1'b0, mac_ctrl_pkg::ADR_RXCNT, 32'h0);
      chk(rdat, 32'h0);
      chk({sta, thr}, {a[15:0], a, ~a[15:0]});
      frame(3, 1'b0, 1'b1);
      $display("done: soft reset");
      wb(1'b1, CMD, 32'h7);
      @(posedge clk_i);
      tx_en <= 1'b1;
      txd <= 8'h5A;
      wb(1'b1, CMD, 32'hF);
      wb(1'b0, CMD, 32'h0);
      chk(rdat & 32'hB, 32'h8);
      chk(phy_tx_en_o, 1'b1);
      wb(1'b0, mac_ctrl_pkg::ADR_STATUS, 32'h0);
      chk(rdat[mac_ctrl_pkg::ST_BUSY], 1'b1);
      @(posedge clk_i);
      tx_en <= 1'b0;
      wait_rst();
      wb(1'b0, mac_ctrl_pkg::ADR_TXCNT, 32'h0);
      chk(rdat, 32'h0);
      $display("done: reset during frame");
      line_ok <= 1'b0;
      wb(1'b1, CMD, 32'h7);
      frame(2, 1'b1, 1'b1);
      sclr_seen = 1'b0;
      swrst(32'h4);
      wb(1'b0, mac_ctrl_pkg::ADR_TXCNT, 32'h0);
      chk({sclr_seen, rdat}, 33'h1);
      line_ok <= 1'b1;
      swrst(32'h4);
      wb(1'b1, CMD, 32'h3);
      frame(3, 1'b1, 1'b0);
      @(posedge clk_i);
      rx_dv <= 1'b1;
      rxd <= 8'hC3;
      @(posedge clk_i);
      rx_dv <= 1'b0;
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      chk({mac_rx_dv_o, mac_rx_er_o, mac_rxd_o}, 32'h2C3);
      $display("done: leave loopback");
      for (int t = 0; t < 3; t++)
         for (int m = 0; m < 5; m++) begin
            for (int k = 0; k < 5; k++) begin
               rnd = lfsr(rnd);
               dd[k] = rnd[7:0];
               c[k] = enc(rnd[7:0]);
            end
            p = rnd[15:8] % 13;
            if (t > 0) c[m][p] ^= 1'b1;
            if (t > 1) c[m][(p + 1 + rnd[23:16] % 12) % 13] ^= 1'b1;
            @(posedge clk_i);
            cw <= c;
            repeat (2) @(posedge clk_i);
            @(negedge clk_i);
            chk(est, t == 0 ? mac_ctrl_pkg::ECC_OK
                : t == 1 ? mac_ctrl_pkg::ECC_FIXED : mac_ctrl_pkg::ECC_FATAL);
            if (t < 2) chk(edat[m], dd[m]);
         end
      wb(1'b0, mac_ctrl_pkg::ADR_STATUS, 32'h0);
      chk(rdat[5:4], mac_ctrl_pkg::ECC_FATAL);
      $display("done: ecc");
      test_done();
   end
endmodule : mac_rst_loop_ctrl_tb
`default_nettype wire
